// ### include/ilc_consts.vh
// constants for the instruction length and cycle decoder
`ifndef ILC_CONSTS_VH
`define ILC_CONSTS_VH
// axi-lite register byte offsets
`define ILC_OFF_CTRL 8'h00
`define ILC_OFF_INSTR 8'h04
`define ILC_OFF_OPND 8'h08
`define ILC_OFF_RESULT 8'h0c
`define ILC_OFF_TIMING 8'h10
`define ILC_OFF_DPR0 8'h14
`define ILC_OFF_DPR1 8'h18
`define ILC_OFF_DPR2 8'h1c
`define ILC_OFF_DPR3 8'h20
`define ILC_OFF_STATUS 8'h24
`define ILC_OFF_XFER 8'h28
// control register fields
`define ILC_CTRL_M_BIT 0
`define ILC_CTRL_X_BIT 1
`define ILC_CTRL_LONG_BIT 2
`define ILC_CTRL_ZDIV_BIT 3
`define ILC_CTRL_START_BIT 4
`define ILC_CTRL_RESET 32'h0000_0003
// instruction classes (written into instr[7:4])
`define ILC_CL_PLAIN 4'h0
`define ILC_CL_IMM_M 4'h1
`define ILC_CL_IMM_X 4'h2
`define ILC_CL_IMMCNT 4'h3
`define ILC_CL_BRANCH 4'h4
`define ILC_CL_BRK 4'h5
`define ILC_CL_BITN 4'h6
`define ILC_CL_DIV 4'h7
`define ILC_CL_MUL 4'h8
`define ILC_CL_BLK1 4'h9
`define ILC_CL_BLK2 4'ha
`define ILC_CL_RTSD 4'hb
`define ILC_CL_DPRX 4'hc
`define ILC_CL_IMMN 4'hd
`define ILC_CL_XFER 4'he
`define ILC_CL_IMMREP 4'hf
// timing constants in cycles
`define ILC_DIV_EXTRA 8'h08
`define ILC_MUL_EXTRA 8'h04
`define ILC_ZDIV_CYC 16'h0010
`define ILC_BLK_MUL 16'h0005
`define ILC_BLK1_ADD 16'h000a
`define ILC_BLK2_ADD 16'h000e
`define ILC_BLK2_ONE 16'h000a
`define ILC_REP_MUL 16'h0012
`define ILC_REP_ADD 16'h0005
`define ILC_DPR_EXTRA 8'h01
// limits
`define ILC_IMM_MAX 5'h1f
`define ILC_BITN_MAX 4'hf
`define ILC_B_PREFIX 8'h81
`define ILC_DBG_ID 32'h0000_5a5a
`endif

// ### rtl/ilc_calc.v
// combinational length and cycle calculation for one decoded instruction
`timescale 1ns/1ps
`include "ilc_consts.vh"
module ilc_calc (
    input wire [31:0] instr,
    input wire [31:0] opnd,
    input wire [15:0] dpr_low_nz,
    input wire flag_m,
    input wire flag_x,
    input wire long_op,
    input wire zero_div,
    output reg [7:0] length,
    output reg [15:0] cycles,
    output reg acc_b,
    output reg disp_long,
    output reg debug_only,
    output reg illegal,
    output reg [7:0] opcode_out,
    output reg [3:0] dpr_mask
);
    wire [3:0] cls = instr[7:4];
    wire [3:0] base_len = instr[3:0];
    wire [7:0] base_cyc = instr[15:8];
    wire [7:0] op = instr[23:16];
    wire [7:0] prefix = instr[31:24];
    wire [15:0] cnt = opnd[15:0];

    // per-class length and cycle adjustment; counts are minimum figures
    always @* begin
        length = {4'h0, base_len};
        cycles = {8'h00, base_cyc};
        acc_b = (prefix == `ILC_B_PREFIX);
        disp_long = 1'b0;
        debug_only = 1'b0;
        illegal = 1'b0;
        opcode_out = op;
        dpr_mask = 4'h0;
        // dpr addressing adds a cycle if the used register's low byte is nonzero;
        // the dpr-indexed class (ILC_CL_DPRX) names its register in opnd[1:0]
        if (cls == `ILC_CL_DPRX && opnd[7:2] == 6'h00) begin
            if (dpr_low_nz[{opnd[1:0], 2'b00}]) begin
                cycles = cycles + {8'h00, `ILC_DPR_EXTRA};
            end
        end
        case (cls)
            `ILC_CL_IMM_M: if (!flag_m) length = length + 8'h01;
            `ILC_CL_IMM_X: if (!flag_x) length = length + 8'h01;
            `ILC_CL_IMMCNT: begin
                if (opnd[7:5] != 3'b000) illegal = 1'b1;
                else opcode_out = op + {3'b000, opnd[4:0]};
            end
            `ILC_CL_BRANCH: begin
                disp_long = long_op;
                length = length + (long_op ? 8'h02 : 8'h01);
            end
            `ILC_CL_BRK: debug_only = 1'b1;
            `ILC_CL_BITN: if (opnd[7:4] != 4'h0) illegal = 1'b1;
            `ILC_CL_DIV: begin
                if (zero_div) cycles = `ILC_ZDIV_CYC;
                else if (long_op) cycles = cycles + {8'h00, `ILC_DIV_EXTRA};
            end
            `ILC_CL_MUL: if (long_op) cycles = cycles + {8'h00, `ILC_MUL_EXTRA};
            `ILC_CL_BLK1: if (cnt[0]) cycles = cnt * `ILC_BLK_MUL + `ILC_BLK1_ADD;
            `ILC_CL_BLK2: begin
                if (cnt == 16'h0001) cycles = `ILC_BLK2_ONE;
                else if (cnt[0]) cycles = cnt * `ILC_BLK_MUL + `ILC_BLK2_ADD;
            end
            `ILC_CL_RTSD: begin
                dpr_mask = opnd[3:0];
                if (opnd[3:0] == 4'h0) illegal = 1'b1;
                // single register uses first opcode, several use the second
                if (opnd[3:0] == 4'h1 || opnd[3:0] == 4'h2 || opnd[3:0] == 4'h4 ||
                        opnd[3:0] == 4'h8) opcode_out = op;
                else opcode_out = op + 8'h01;
            end
            `ILC_CL_DPRX: begin
                if (opnd[7:2] != 6'h00) illegal = 1'b1;
                else opcode_out = op | {2'b00, opnd[1:0], 4'h0};
            end
            `ILC_CL_IMMN: if (!flag_m) length = length + {4'h0, opnd[3:0]};
            `ILC_CL_IMMREP: if (!flag_m) cycles = cnt * `ILC_REP_MUL + `ILC_REP_ADD;
            default: ;
        endcase
    end
endmodule

// ### rtl/ilc_top.v
// decoder block: axi-lite register shell around the length/cycle calculator
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ilc_consts.vh"
module ilc_top #(
    parameter DBG_ID = `ILC_DBG_ID // arbitrary identification value
) (
    input wire REF_CLK,
    input wire RST,
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    output reg DEBUG_BREAK,
    output reg ILLEGAL
);
    reg [31:0] ctrl;
    reg [31:0] instr;
    reg [31:0] opnd;
    reg [15:0] direct_page_reg [0:3];
    reg [31:0] result;
    reg [31:0] timing;
    reg [31:0] status;
    reg [7:0] aw_addr;
    reg aw_have;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_have;
    wire [7:0] c_len;
    wire [15:0] c_cyc;
    wire c_accb;
    wire c_long;
    wire c_dbg;
    wire c_ill;
    wire [7:0] c_op;
    wire [3:0] c_mask;
    wire [15:0] dpr_low_nz;
    wire flag_m = ctrl[`ILC_CTRL_M_BIT];
    wire flag_x = ctrl[`ILC_CTRL_X_BIT];
    wire do_write = aw_have && w_have && !S_AXI_BVALID;
    genvar g;

    // low-byte nonzero indication per direct page register, spaced by four bits
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_nz
            assign dpr_low_nz[g*4] = (direct_page_reg[g][7:0] != 8'h00);
            assign dpr_low_nz[g*4+3:g*4+1] = 3'b000;
        end
    endgenerate

    ilc_calc u_calc (
        .instr(instr),
        .opnd(opnd),
        .dpr_low_nz(dpr_low_nz),
        .flag_m(flag_m),
        .flag_x(flag_x),
        .long_op(ctrl[`ILC_CTRL_LONG_BIT]),
        .zero_div(ctrl[`ILC_CTRL_ZDIV_BIT]),
        .length(c_len),
        .cycles(c_cyc),
        .acc_b(c_accb),
        .disp_long(c_long),
        .debug_only(c_dbg),
        .illegal(c_ill),
        .opcode_out(c_op),
        .dpr_mask(c_mask)
    );

    // write address and data channels, taken in either order
    always @(posedge REF_CLK) begin
        if (RST) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            S_AXI_AWREADY <= !aw_have && !S_AXI_AWREADY && S_AXI_AWVALID;
            S_AXI_WREADY <= !w_have && !S_AXI_WREADY && S_AXI_WVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end else if (do_write) begin
                aw_have <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end else if (do_write) begin
                w_have <= 1'b0;
            end
        end
    end

    // byte-lane merge helper
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] st;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (st[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    // registers are 16 bits, so the upper half of the merged word is dropped on purpose
    wire [1:0] dpr_wr_idx = aw_addr[3:2] - 2'b01;
    wire [31:0] dpr_merged = merge({16'h0, direct_page_reg[dpr_wr_idx]}, w_data, w_strb);

    // register writes, decode start and response
    always @(posedge REF_CLK) begin
        if (RST) begin
            ctrl <= `ILC_CTRL_RESET;
            instr <= 32'h0000_0000;
            opnd <= 32'h0000_0000;
            direct_page_reg[0] <= 16'h0000;
            direct_page_reg[1] <= 16'h0000;
            direct_page_reg[2] <= 16'h0000;
            direct_page_reg[3] <= 16'h0000;
            result <= 32'h0000_0000;
            timing <= 32'h0000_0000;
            status <= 32'h0000_0000;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'b00;
            DEBUG_BREAK <= 1'b0;
            ILLEGAL <= 1'b0;
        end else begin
            if (S_AXI_BVALID && S_AXI_BREADY) S_AXI_BVALID <= 1'b0;
            if (do_write) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= 2'b00;
                if (aw_addr[7:2] == 6'h00) begin
                    ctrl <= merge(ctrl, w_data, w_strb) & 32'h0000_000f;
                    if (w_strb[0] && w_data[`ILC_CTRL_START_BIT]) begin
                        // latch calculated length, cycles and decode flags
                        result <= {4'h0, c_mask, c_op, 4'h0, c_ill, c_dbg, c_long, c_accb,
                            c_len};
                        timing <= {16'h0000, c_cyc};
                        DEBUG_BREAK <= c_dbg;
                        ILLEGAL <= c_ill;
                        status <= {30'h0, c_ill, 1'b1};
                    end
                end else if (aw_addr == `ILC_OFF_INSTR) begin
                    instr <= merge(instr, w_data, w_strb);
                end else if (aw_addr == `ILC_OFF_OPND) begin
                    opnd <= merge(opnd, w_data, w_strb);
                end else if (aw_addr >= `ILC_OFF_DPR0 && aw_addr <= `ILC_OFF_DPR3) begin
                    direct_page_reg[dpr_wr_idx] <= dpr_merged[15:0];
                end else if (aw_addr == `ILC_OFF_XFER) begin
                    // copy one direct page register into another at flag width
                    if (flag_m)
                        direct_page_reg[w_data[3:2]] <= {direct_page_reg[w_data[3:2]][15:8],
                            direct_page_reg[w_data[1:0]][7:0]};
                    else
                        direct_page_reg[w_data[3:2]] <= direct_page_reg[w_data[1:0]];
                end else if (aw_addr != `ILC_OFF_RESULT && aw_addr != `ILC_OFF_TIMING &&
                        aw_addr != `ILC_OFF_STATUS) begin
                    S_AXI_BRESP <= 2'b10;
                end
            end
        end
    end

    // read channel; one cycle from address taken to data
    always @(posedge REF_CLK) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= 2'b00;
        end else begin
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
            if (S_AXI_RVALID && S_AXI_RREADY) S_AXI_RVALID <= 1'b0;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= 2'b00;
                if (S_AXI_ARADDR == `ILC_OFF_CTRL) S_AXI_RDATA <= ctrl;
                else if (S_AXI_ARADDR == `ILC_OFF_INSTR) S_AXI_RDATA <= instr;
                else if (S_AXI_ARADDR == `ILC_OFF_OPND) S_AXI_RDATA <= opnd;
                else if (S_AXI_ARADDR == `ILC_OFF_RESULT) S_AXI_RDATA <= result;
                else if (S_AXI_ARADDR == `ILC_OFF_TIMING) S_AXI_RDATA <= timing;
                else if (S_AXI_ARADDR == `ILC_OFF_STATUS) S_AXI_RDATA <= status;
                else if (S_AXI_ARADDR >= `ILC_OFF_DPR0 && S_AXI_ARADDR <= `ILC_OFF_DPR3)
                    S_AXI_RDATA <= {16'h0, direct_page_reg[S_AXI_ARADDR[3:2] - 2'b01]};
                else begin
                    S_AXI_RDATA <= 32'h0000_0000;
                    S_AXI_RRESP <= 2'b10;
                end
            end
        end
    end
endmodule

// ### testbench/ilc_props.sv
// bus handshake and status checks for the decoder block
`timescale 1ns/1ps
module ilc_props (
    input wire REF_CLK,
    input wire RST,
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    input wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    input wire S_AXI_WREADY,
    input wire [1:0] S_AXI_BRESP,
    input wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    input wire S_AXI_ARREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire [1:0] S_AXI_RRESP,
    input wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire DEBUG_BREAK,
    input wire ILLEGAL
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // readies are one-cycle pulses, so a held ready means a lost handshake
    property p_aw_pulse; S_AXI_AWREADY |=> !S_AXI_AWREADY; endproperty
    a_aw_pulse: assert property (p_aw_pulse) else $error("aw ready held");
    property p_w_pulse; S_AXI_WREADY |=> !S_AXI_WREADY; endproperty
    a_w_pulse: assert property (p_w_pulse) else $error("w ready held");
    property p_ar_pulse; S_AXI_ARREADY |=> !S_AXI_ARREADY; endproperty
    a_ar_pulse: assert property (p_ar_pulse) else $error("ar ready held");
    // answers come in bounded time and stand until taken
    property p_b_answer; S_AXI_AWVALID && S_AXI_AWREADY |-> ##[1:4] S_AXI_BVALID; endproperty
    a_b_answer: assert property (p_b_answer) else $error("write answer missing");
    property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_answer; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_r_resp; S_AXI_RVALID |-> S_AXI_RRESP == 2'h0 || S_AXI_RRESP == 2'h2; endproperty
    a_r_resp: assert property (p_r_resp) else $error("read response code bad");
    // reset clears the decode flags, checked while reset itself is active
    property p_rst_quiet;
        disable iff (1'b0) RST |=> !S_AXI_BVALID && !S_AXI_RVALID && !DEBUG_BREAK && !ILLEGAL;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy in reset");
    // decode flags move only together with the write answer of a start strobe
    property p_flag_move;
        $changed(DEBUG_BREAK) || $changed(ILLEGAL) |-> $rose(S_AXI_BVALID);
    endproperty
    a_flag_move: assert property (p_flag_move) else $error("flag moved off a write");
    c_wr: cover property (S_AXI_BVALID && S_AXI_BREADY);
    c_err: cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
    c_dbg: cover property (DEBUG_BREAK);
    c_ill: cover property (ILLEGAL);
endmodule

// ### testbench/tb_ilc_top.sv
// self-checking bench for the decoder block
`timescale 1ns/1ps
`include "ilc_consts.vh"
module tb_ilc_top;
    logic REF_CLK = 1'b0;
    logic RST = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, dbg, ill;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    logic [31:0] res, tim, d;
    logic [1:0] r;
    integer bad_count = 0;
    integer samples_checked = 0;
    integer cyc_n = 0;
    ilc_top dut_u (.REF_CLK(REF_CLK), .RST(RST), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .DEBUG_BREAK(dbg), .ILLEGAL(ill));
    initial begin
        forever #4 REF_CLK = ~REF_CLK;
    end
    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang guard, far above the roughly 840 cycles the run needs
    always @(posedge REF_CLK) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            bad_count = bad_count + 1;
            test_done();
        end
    end
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask
    // values read at a rising edge are the ones the slave samples there; each task
    // lets one edge pass first so back-to-back calls never drive twice in a step
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        integer n;
        n = 0;
        @(posedge REF_CLK);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge REF_CLK);
            n = n + 1;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 40);
        r = bresp;
        bready <= 1'b0;
        chk("write answer", 32'h1, {31'h0, bvalid});
    endtask
    task automatic rd(input logic [7:0] a);
        integer n;
        n = 0;
        @(posedge REF_CLK);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge REF_CLK);
            n = n + 1;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 40);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        chk("read answer", 32'h1, {31'h0, rvalid});
    endtask
    function automatic logic [31:0] mk(input logic [7:0] p, o, c, input logic [3:0] k, l);
        return {p, o, c, k, l};
    endfunction
    // load operand and instruction, start, wait for done, fetch both results
    task automatic go(input logic [31:0] c, input logic [31:0] i, input logic [31:0] o);
        integer n;
        wr(`ILC_OFF_OPND, o);
        wr(`ILC_OFF_INSTR, i);
        // flags first: the start strobe decodes with the flags already held
        wr(`ILC_OFF_CTRL, c);
        wr(`ILC_OFF_CTRL, c | 32'h10);
        n = 0;
        d = 32'h0;
        while (d[0] !== 1'b1 && n < 20) begin
            rd(`ILC_OFF_STATUS);
            n = n + 1;
        end
        chk("done", 32'h1, {31'h0, d[0]});
        rd(`ILC_OFF_RESULT);
        res = d;
        rd(`ILC_OFF_TIMING);
        tim = d & 32'hffff;
    endtask
    task t_reset;
        chk("dbg", 32'h0, {31'h0, dbg}); chk("ill", 32'h0, {31'h0, ill});
        rd(`ILC_OFF_CTRL); chk("ctrl", `ILC_CTRL_RESET, d);
        rd(8'h40); chk("rd resp", 32'h2, {30'h0, r}); chk("rd data", 32'h0, d);
        wr(8'h44, 32'hffff_ffff); chk("wr resp", 32'h2, {30'h0, r});
        $display("reset and map test done");
    endtask
    task t_len;
        go(32'h2, mk(8'h00, 8'h10, 8'h02, `ILC_CL_IMM_M, 4'h2), 0);
        chk("len m0", 32'h3, res & 32'hff);
        go(32'h3, mk(8'h00, 8'h10, 8'h02, `ILC_CL_IMM_M, 4'h2), 0);
        chk("len m1", 32'h2, res & 32'hff);
        go(32'h1, mk(8'h00, 8'h11, 8'h02, `ILC_CL_IMM_X, 4'h2), 0);
        chk("len x0", 32'h3, res & 32'hff);
        go(32'h2, mk(8'h00, 8'h12, 8'h02, `ILC_CL_IMMN, 4'h2), 32'hf);
        chk("len n", 32'h11, res & 32'hff);
        $display("length test done");
    endtask
    task t_cyc;
        go(32'h3, mk(8'h00, 8'h20, 8'd20, `ILC_CL_DIV, 4'h2), 0);
        chk("div", 20, tim);
        go(32'h7, mk(8'h00, 8'h20, 8'd20, `ILC_CL_DIV, 4'h2), 0);
        chk("div l", 28, tim);
        go(32'hf, mk(8'h00, 8'h20, 8'd20, `ILC_CL_DIV, 4'h2), 0);
        chk("zdiv", 16, tim);
        go(32'hb, mk(8'h00, 8'h20, 8'd20, `ILC_CL_DIV, 4'h2), 0);
        chk("zdiv s", 16, tim);
        go(32'h7, mk(8'h00, 8'h21, 8'd10, `ILC_CL_MUL, 4'h2), 0);
        chk("mul l", 14, tim);
        go(32'h3, mk(8'h00, 8'h22, 8'd9, `ILC_CL_BLK1, 4'h2), 3);
        chk("blk1", 25, tim);
        go(32'h3, mk(8'h00, 8'h23, 8'd9, `ILC_CL_BLK2, 4'h2), 3);
        chk("blk2", 29, tim);
        go(32'h3, mk(8'h00, 8'h23, 8'd9, `ILC_CL_BLK2, 4'h2), 1);
        chk("blk2 1", 10, tim);
        go(32'h2, mk(8'h00, 8'h24, 8'd6, `ILC_CL_IMMREP, 4'h2), 2);
        chk("rep", 41, tim);
        go(32'h3, mk(8'h00, 8'h24, 8'd6, `ILC_CL_IMMREP, 4'h2), 2);
        chk("rep m1", 6, tim);
        wr(`ILC_OFF_DPR2, 32'h0100);
        go(32'h3, mk(8'h00, 8'h25, 8'd5, `ILC_CL_DPRX, 4'h2), 2);
        chk("dpr z", 5, tim);
        wr(`ILC_OFF_DPR2, 32'h0101);
        go(32'h3, mk(8'h00, 8'h05, 8'd5, `ILC_CL_DPRX, 4'h2), 2);
        chk("dpr nz", 6, tim);
        chk("dpr op", 32'h25, (res >> 16) & 32'hff);
        $display("cycle test done");
    endtask
    task t_flags;
        go(32'h3, mk(8'h00, 8'h00, 8'd7, `ILC_CL_BRK, 4'h1), 0);
        chk("dbg", 32'h1, {31'h0, dbg});
        go(32'h3, mk(8'h00, 8'h30, 8'd4, `ILC_CL_BITN, 4'h2), 15);
        chk("n15", 0, {31'h0, ill});
        go(32'h3, mk(8'h00, 8'h30, 8'd4, `ILC_CL_BITN, 4'h2), 16);
        chk("n16", 1, {31'h0, ill});
        go(32'h3, mk(8'h00, 8'h40, 8'd2, `ILC_CL_IMMCNT, 4'h1), 31);
        chk("imm op", 32'h5f, (res >> 16) & 32'hff);
        go(32'h3, mk(8'h00, 8'h40, 8'd2, `ILC_CL_IMMCNT, 4'h1), 32);
        chk("imm32", 1, {31'h0, ill});
        go(32'h3, mk(`ILC_B_PREFIX, 8'h26, 8'd3, `ILC_CL_PLAIN, 4'h2), 0);
        chk("acc b", 32'h1, (res >> 8) & 32'h1);
        go(32'h7, mk(8'h00, 8'h27, 8'd3, `ILC_CL_BRANCH, 4'h3), 0);
        chk("br long", 32'h1, (res >> 9) & 32'h1);
        chk("br len", 32'h5, res & 32'hff);
        go(32'h3, mk(8'h00, 8'h28, 8'd9, `ILC_CL_RTSD, 4'h2), 32'h5);
        chk("mask", 32'h5, (res >> 24) & 32'hf);
        chk("rtsd op", 32'h29, (res >> 16) & 32'hff);
        wr(`ILC_OFF_DPR0, 32'h1234);
        wr(`ILC_OFF_CTRL, 32'h0);
        wr(`ILC_OFF_XFER, 32'h4);
        rd(`ILC_OFF_DPR1);
        chk("xfer dst", 32'h1234, d);
        rd(`ILC_OFF_DPR0);
        chk("xfer src", 32'h1234, d);
        // byte-wide copy keeps the destination's high byte
        wr(`ILC_OFF_CTRL, 32'h1);
        wr(`ILC_OFF_XFER, 32'h8);
        rd(`ILC_OFF_DPR2);
        chk("xfer byte", 32'h0134, d);
        $display("flag test done");
    endtask
    initial begin
        repeat (10) @(posedge REF_CLK);
        RST <= 1'b0;
        @(posedge REF_CLK);
        t_reset();
        t_len();
        t_cyc();
        t_flags();
        test_done();
    end
endmodule
bind ilc_top ilc_props chk_u (.REF_CLK(REF_CLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .DEBUG_BREAK(DEBUG_BREAK), .ILLEGAL(ILLEGAL));
